// ---- logic/dtc_map.svh ----
// Register offsets, field positions and reset values of the trigger unit
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_OFF_CTRL   8'h00
`define DTC_OFF_CMPA   8'h04
`define DTC_OFF_CMPB   8'h08
`define DTC_OFF_STAT   8'h0c
`define DTC_OFF_FIFO   8'h10
`define DTC_OFF_ISTS   8'h14
`define DTC_OFF_IMSK   8'h18
`define DTC_CTRL_RST   32'h0000_0000
`define DTC_CMP_RST    32'h0000_0000
`define DTC_ST_RUN_ACTIVE_FLAG    7
`define DTC_ST_AF      6
`define DTC_ST_BF      5
`define DTC_IRQ_A      0
`define DTC_IRQ_B      1
`define DTC_IRQ_END    2
`define DTC_IRQ_W      3
`define DTC_FIFO_DEP   8
`define DTC_FIFO_WID   16
`endif

// ---- logic/dtc_pkg.sv ----
// Types shared by the debug trigger and capture unit
package dtc_pkg;
	// Trigger modes, one value each
	typedef enum logic [3:0] {
		DTC_A_ONLY    = 4'h0,
		DTC_A_OR_B    = 4'h1,
		DTC_A_THEN_B  = 4'h2,
		DTC_EV_B      = 4'h3,
		DTC_A_THEN_EV = 4'h4,
		DTC_A_AND_B   = 4'h5,
		DTC_A_NOT_B   = 4'h6,
		DTC_INSIDE    = 4'h7,
		DTC_OUTSIDE   = 4'h8
	} dtc_mode_t;
	// Run states, one-hot
	typedef enum logic [2:0] {
		DTC_IDLE  = 3'b001,
		DTC_ARMED = 3'b010,
		DTC_TRACE = 3'b100
	} dtc_run_t;
	// Control register layout, bit 0 lowest
	typedef struct packed {
		logic [15:0] rsvd;
		logic [3:0]  trigger_mode_field;
		logic [1:0]  rsvd2;
		logic        rw_match_value_b;
		logic        rw_qualify_enable_b;
		logic        rw_match_value_a;
		logic        rw_qualify_enable_a;
		logic        opcode_qualify_select;
		logic        begin_trace;
		logic        breakpoint_request_enable;
		logic        tag_select;
		logic        arm;
		logic        debug_module_enable;
	} dtc_ctrl_t;
	// One CPU bus cycle as seen by the comparators
	typedef struct packed {
		logic        valid;
		logic        fetch;
		logic        rw;
		logic [15:0] addr;
		logic [7:0]  data;
	} dtc_bus_t;
	// Core progress: executed opcode, change of flow, queue flush
	typedef struct packed {
		logic        exec_valid;
		logic [15:0] exec_addr;
		logic        cof_valid;
		logic [15:0] cof_addr;
		logic        flush;
	} dtc_core_t;
endpackage

// ---- logic/dtc_unit.sv ----
// Debug trigger and capture unit with its register slave
//
// Operation
// - Two address comparators, or address plus data
// - Capture FIFO eight entries of sixteen bits
// - Four-bit field selects nine trigger modes
// - Basic, sequence, full and event-only modes
// - Inside and outside address range modes
// - Entries hold flow addresses or event data
// - Opcode qualify: non-range modes trigger only when opcode executes
// - Separate opcode tracker for each comparator
// - Tag request marks opcode for background entry
// - Force request acts after current instruction
// - Begin select: begin-trace or circular end-trigger
// - Arm sets run flag, clears flags, count
// - Begin run ends full; end run on trigger
// - Clearing arm or enable stops the run
// - Event-only modes always run as begin-trace
// - Per comparator read/write qualification
// - Breakpoints need enable; kind selects tag/force
// - Background command wakes CPU from stop/wait
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "dtc_map.svh"
module dtc_unit import dtc_pkg::*; #(
	parameter int DEPTH = `DTC_FIFO_DEP,
	parameter int WIDTH = `DTC_FIFO_WID
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU side
	input  wire dtc_bus_t    cpu_bus,
	input  wire dtc_core_t   core,
	input  wire logic        background_opcode_cmd,
	output logic             brk_tag,
	output logic             brk_force,
	output logic             cpu_wake,
	// Interrupt
	output logic             irq
);
	// Count is one bit wider than the pointers to tell full from empty
	localparam int AW = $clog2(DEPTH);

	// The pointers wrap by width, so only this shape is served
	if (DEPTH != 8 || WIDTH != 16) begin : g_chk
		$error("dtc_unit: FIFO must be 8 by 16");
	end

	// All state of the unit
	typedef struct packed {
		dtc_run_t                     st;
		dtc_ctrl_t                    ctrl;
		logic [15:0]                  cmpa;
		logic [23:0]                  cmpb;
		logic                         af;
		logic                         bf;
		logic [AW:0]                  cnt;
		logic [AW-1:0]                wp;
		logic [AW-1:0]                rp;
		logic [DEPTH-1:0][WIDTH-1:0]  mem;
		logic                         pa_v;
		logic [15:0]                  pa_addr;
		logic                         pb_v;
		logic [15:0]                  pb_addr;
		logic [`DTC_IRQ_W-1:0]        ists;
		logic [`DTC_IRQ_W-1:0]        imsk;
		logic                         irq;
		logic                         brk_tag;
		logic                         brk_force;
		logic                         wake;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
	} dtc_regs_t;

	dtc_regs_t r_ff;     // Registered state
	dtc_regs_t nxt_r;    // Next state

	// Comparator match with optional read/write qualification
	function automatic logic cmp_hit(
		input logic [15:0] a,
		input logic [15:0] ref_a,
		input logic        rw,
		input logic        rwen,
		input logic        rwv
	);
		cmp_hit = (a == ref_a) && (!rwen || rw == rwv);
	endfunction

	// Offset decode, also used for the error answer
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`DTC_OFF_CTRL, `DTC_OFF_CMPA, `DTC_OFF_CMPB,
			`DTC_OFF_STAT, `DTC_OFF_FIFO, `DTC_OFF_ISTS,
			`DTC_OFF_IMSK: mapped = 1'b1;
			default:       mapped = 1'b0;
		endcase
	endfunction

	// Combinational helpers
	logic       raw_a;      // Comparator A on this bus cycle
	logic       raw_b;      // Comparator B on this bus cycle
	logic       hit_a;      // A after opcode qualification
	logic       hit_b;      // B after opcode qualification
	logic       data_eq;    // Data byte equals B data
	logic       trig;       // Selected trigger condition
	logic       ev_mode;    // Event-only mode selected
	logic       ev_store;   // Event data to capture now
	logic       cof_store;  // Flow address to capture now
	logic       do_store;   // Any capture this cycle
	logic [15:0] st_word;   // Word to store
	logic       running;    // Run active
	logic       beg_eff;    // Effective begin-trace choice
	logic       wr_acc;     // APB write completes
	logic       rd_acc;     // APB read completes
	logic       pop;        // Software read of FIFO
	logic       arm_wr;     // Write arming a run
	logic       stop_wr;    // Write stopping a run
	logic       full;       // FIFO holds DEPTH words
	logic       run_end;    // Run ends this cycle
	dtc_ctrl_t  wctl;       // Write data as control
	dtc_mode_t  mode;       // Current trigger mode
	logic [`DTC_IRQ_W-1:0] ev;  // Interrupt events

	// Next state of everything
	always_comb begin
		nxt_r   = r_ff;
		wctl    = dtc_ctrl_t'(pwdata);
		mode    = dtc_mode_t'(r_ff.ctrl.trigger_mode_field);
		running = (r_ff.st != DTC_IDLE);
		full    = (r_ff.cnt == (AW+1)'(DEPTH));

		// Comparators with read/write qualification
		raw_a = cpu_bus.valid && cmp_hit(cpu_bus.addr, r_ff.cmpa,
			cpu_bus.rw, r_ff.ctrl.rw_qualify_enable_a,
			r_ff.ctrl.rw_match_value_a);
		raw_b = cpu_bus.valid && cmp_hit(cpu_bus.addr, r_ff.cmpb[15:0],
			cpu_bus.rw, r_ff.ctrl.rw_qualify_enable_b,
			r_ff.ctrl.rw_match_value_b);
		data_eq = (cpu_bus.data == r_ff.cmpb[23:16]);

		// Opcode trackers: a fetch hit waits for its execution
		if (r_ff.ctrl.opcode_qualify_select) begin
			hit_a = r_ff.pa_v && core.exec_valid &&
				core.exec_addr == r_ff.pa_addr;
			hit_b = r_ff.pb_v && core.exec_valid &&
				core.exec_addr == r_ff.pb_addr;
		end else begin
			hit_a = raw_a;
			hit_b = raw_b;
		end
		// One tracker per comparator, both may be pending
		if (core.flush || hit_a) begin
			nxt_r.pa_v = 1'b0;
		end
		if (core.flush || hit_b) begin
			nxt_r.pb_v = 1'b0;
		end
		if (raw_a && cpu_bus.fetch && !core.flush) begin
			nxt_r.pa_v    = 1'b1;
			nxt_r.pa_addr = cpu_bus.addr;
		end
		if (raw_b && cpu_bus.fetch && !core.flush) begin
			nxt_r.pb_v    = 1'b1;
			nxt_r.pb_addr = cpu_bus.addr;
		end

		// Trigger selection
		ev_mode = (mode == DTC_EV_B) || (mode == DTC_A_THEN_EV);
		case (mode)
			DTC_A_ONLY:    trig = hit_a;
			DTC_A_OR_B:    trig = hit_a || hit_b;
			DTC_A_THEN_B:  trig = (r_ff.af || hit_a) && hit_b;
			DTC_EV_B:      trig = hit_b;
			DTC_A_THEN_EV: trig = r_ff.af && hit_b;
			DTC_A_AND_B:   trig = hit_a && data_eq;
			DTC_A_NOT_B:   trig = hit_a && !data_eq;
			DTC_INSIDE:    trig = cpu_bus.valid &&
				cpu_bus.addr >= r_ff.cmpa &&
				cpu_bus.addr <= r_ff.cmpb[15:0];
			DTC_OUTSIDE:   trig = cpu_bus.valid &&
				(cpu_bus.addr < r_ff.cmpa ||
				cpu_bus.addr > r_ff.cmpb[15:0]);
			default:       trig = 1'b0;  // Unused codes never fire
		endcase
		trig = trig && running;

		// Event modes ignore the begin choice
		beg_eff = r_ff.ctrl.begin_trace || ev_mode;

		// Capture: data in event modes, else flow addresses
		ev_store  = running && ev_mode && trig;
		cof_store = !ev_mode && core.cof_valid &&
			(r_ff.st == DTC_TRACE ||
			(r_ff.st == DTC_ARMED && !beg_eff));
		do_store  = ev_store || cof_store;
		st_word   = ev_store ? {8'h00, cpu_bus.data} :
			core.cof_addr;

		// Bus phases: answer in the first access cycle
		wr_acc  = psel && penable && r_ff.pready && pwrite;
		rd_acc  = psel && penable && r_ff.pready && !pwrite;
		pop     = rd_acc && paddr == `DTC_OFF_FIFO &&
			r_ff.cnt != '0 && !r_ff.pslverr;
		arm_wr  = wr_acc && paddr == `DTC_OFF_CTRL && wctl.arm &&
			wctl.debug_module_enable;
		stop_wr = wr_acc && paddr == `DTC_OFF_CTRL &&
			(!wctl.arm || !wctl.debug_module_enable);

		// FIFO pointers and count
		// Pop and store together leave the count where it was
		if (pop) begin
			nxt_r.rp  = r_ff.rp + 1'b1;
			nxt_r.cnt = r_ff.cnt - 1'b1;
		end
		if (do_store) begin
			nxt_r.mem[r_ff.wp] = st_word;
			nxt_r.wp = r_ff.wp + 1'b1;
			if (full) begin
				// Circular store drops the oldest word
				nxt_r.rp = r_ff.rp + 1'b1;
				nxt_r.cnt = r_ff.cnt;
			end else if (!pop) begin
				nxt_r.cnt = r_ff.cnt + 1'b1;
			end else begin
				nxt_r.cnt = r_ff.cnt;
			end
		end

		// Comparator flags, sticky within a run
		// Only arming a new run clears them again
		if (running && hit_a) begin
			nxt_r.af = 1'b1;
		end
		if (running && (hit_b || (trig && !ev_mode &&
			mode != DTC_A_ONLY))) begin
			nxt_r.bf = 1'b1;
		end

		// Run sequencing
		// The arm bit clears itself at the end so software can poll it
		run_end = 1'b0;
		case (r_ff.st)
			DTC_IDLE: begin
				nxt_r.st = DTC_IDLE;
			end
			DTC_ARMED: begin
				if (ev_mode) begin
					// Event runs store until full
					if (do_store && nxt_r.cnt == (AW+1)'(DEPTH)) begin
						run_end = 1'b1;
					end
				end else if (trig && beg_eff) begin
					nxt_r.st = DTC_TRACE;
				end else if (trig) begin
					run_end = 1'b1;
				end
			end
			DTC_TRACE: begin
				if (do_store && nxt_r.cnt == (AW+1)'(DEPTH)) begin
					run_end = 1'b1;
				end
			end
			default: begin
				nxt_r.st = DTC_IDLE;
			end
		endcase
		if (run_end) begin
			nxt_r.st       = DTC_IDLE;
			nxt_r.ctrl.arm = 1'b0;
		end

		// Breakpoint requests to the core, one pulse each
		// A tag goes out on the fetch; the core acts only if it executes
		nxt_r.brk_tag   = r_ff.ctrl.breakpoint_request_enable &&
			r_ff.ctrl.tag_select && running &&
			((raw_a || raw_b) && cpu_bus.fetch);
		nxt_r.brk_force = r_ff.ctrl.breakpoint_request_enable &&
			!r_ff.ctrl.tag_select && trig;
		// Background command wakes a stopped or waiting core
		nxt_r.wake = background_opcode_cmd;

		// Register writes
		if (wr_acc) begin
			case (paddr)
				`DTC_OFF_CTRL: begin
					nxt_r.ctrl = wctl;
				end
				`DTC_OFF_CMPA: nxt_r.cmpa = pwdata[15:0];
				`DTC_OFF_CMPB: nxt_r.cmpb = pwdata[23:0];
				`DTC_OFF_IMSK: nxt_r.imsk = pwdata[`DTC_IRQ_W-1:0];
				default: ;  // Others are read-only or handled below
			endcase
		end
		if (arm_wr) begin
			nxt_r.st  = DTC_ARMED;
			nxt_r.af  = 1'b0;
			nxt_r.bf  = 1'b0;
			nxt_r.cnt = '0;
			nxt_r.wp  = '0;
			nxt_r.rp  = '0;
		end else if (stop_wr) begin
			nxt_r.st = DTC_IDLE;
		end

		// Interrupt status: set wins over a same-cycle clear
		ev = '0;
		ev[`DTC_IRQ_A]   = nxt_r.af && !r_ff.af;
		ev[`DTC_IRQ_B]   = nxt_r.bf && !r_ff.bf;
		ev[`DTC_IRQ_END] = run_end;
		if (wr_acc && paddr == `DTC_OFF_ISTS) begin
			nxt_r.ists = r_ff.ists & ~pwdata[`DTC_IRQ_W-1:0];
		end
		nxt_r.ists = nxt_r.ists | ev;
		nxt_r.irq  = |(nxt_r.ists & nxt_r.imsk);

		// APB answer: data latched in setup, ready in access
		// The FIFO word is chosen at setup and popped at access; a store
		// between the two may move the oldest word, so read when stopped
		nxt_r.pready = psel && !penable;
		if (psel && !penable) begin
			nxt_r.pslverr = !mapped(paddr);
			case (paddr)
				`DTC_OFF_CTRL: nxt_r.prdata = r_ff.ctrl;
				`DTC_OFF_CMPA: nxt_r.prdata = {16'h0000, r_ff.cmpa};
				`DTC_OFF_CMPB: nxt_r.prdata = {8'h00, r_ff.cmpb};
				`DTC_OFF_STAT: nxt_r.prdata = {24'h000000,
					running, r_ff.af, r_ff.bf, 1'b0,
					r_ff.cnt};
				`DTC_OFF_FIFO: nxt_r.prdata = {16'h0000,
					r_ff.cnt != '0 ? r_ff.mem[r_ff.rp] : 16'h0000};
				`DTC_OFF_ISTS: nxt_r.prdata = {29'h00000000,
					r_ff.ists};
				`DTC_OFF_IMSK: nxt_r.prdata = {29'h00000000,
					r_ff.imsk};
				default:       nxt_r.prdata = 32'h00000000;
			endcase
		end
	end

	// State register
	// Reset loads constants only, so no state leaks out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff        <= '0;
			r_ff.st     <= DTC_IDLE;
			r_ff.ctrl   <= `DTC_CTRL_RST;
			r_ff.cmpa   <= 16'h0000;
			r_ff.cmpb   <= 24'h000000;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs straight from flip-flops
	// Registered outputs keep the core free of glitches on its pins
	assign prdata    = r_ff.prdata;
	assign pready    = r_ff.pready;
	assign pslverr   = r_ff.pslverr;
	assign brk_tag   = r_ff.brk_tag;
	assign brk_force = r_ff.brk_force;
	assign cpu_wake  = r_ff.wake;
	assign irq       = r_ff.irq;
endmodule

// ---- bench/dtc_unit_monitor.sv ----
// Port-level checker for the trigger and capture unit
`timescale 1ns/10ps
module dtc_unit_monitor import dtc_pkg::*; #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// CPU side
	input wire dtc_bus_t    cpu_bus,
	input wire logic        background_opcode_cmd,
	input wire logic        brk_tag,
	input wire logic        brk_force,
	input wire logic        cpu_wake
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] ctl_ff; // Shadow of control bits 3:0
	// Follow software writes so break kinds can be judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_ff <= 4'h0;
		end else if (psel && penable && pready && pwrite &&
			paddr == 8'h00) begin
			ctl_ff <= pwdata[3:0];
		end
	end
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	chk_zero_wait: assert property (s_setup |=> s_done)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_map: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped offset accepted");
	chk_wake_delay: assert property (cpu_wake == $past(background_opcode_cmd))
		else $error("wake not one cycle after command");
	chk_force_kind: assert property (
		brk_force |-> (($past(ctl_ff) & 4'hc) == 4'h8))
		else $error("force request of wrong kind");
	chk_tag_kind: assert property (
		brk_tag |-> (($past(ctl_ff) & 4'hc) == 4'hc))
		else $error("tag request of wrong kind");
	chk_tag_fetch: assert property (brk_tag |-> $past(cpu_bus.fetch))
		else $error("tag without opcode fetch");
	chk_cnt_max: assert property (
		pready && !pwrite && paddr == 8'h0c |-> prdata[3:0] <= DEPTH)
		else $error("word count above depth");
endmodule
bind dtc_unit dtc_unit_monitor #(.DEPTH(DEPTH)) mon_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_bus,
	.background_opcode_cmd, .brk_tag, .brk_force, .cpu_wake);

// ---- bench/dtc_cpu_model.sv ----
// CPU core partner: bus cycles, executed opcodes, flow changes
`timescale 1ns/10ps
module dtc_cpu_model import dtc_pkg::*; (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Toward the unit
	output dtc_bus_t  cpu_bus,
	output dtc_core_t core,
	// Break requests
	input  wire logic brk_tag,
	input  wire logic brk_force
);
	int n_tag;   // Tag requests honoured
	int n_force; // Forced background entries
	// Each request sends the core to background mode once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_tag <= 0;
			n_force <= 0;
		end else begin
			n_tag <= n_tag + int'(brk_tag);
			n_force <= n_force + int'(brk_force);
		end
	end
	// One busy cycle, then idle with inverted lines so that a
	// stale address can never pass for a fresh match
	task automatic step(input dtc_bus_t b, input dtc_core_t c);
		@(posedge pclk);
		cpu_bus <= b;
		core <= c;
		@(posedge pclk);
		cpu_bus <= '{1'b0, 1'b0, ~b.rw, ~b.addr, ~b.data};
		core <= '{1'b0, ~c.exec_addr, 1'b0, ~c.cof_addr, 1'b0};
	endtask
	initial begin
		cpu_bus = '0;
		core = '0;
	end
endmodule

// ---- bench/tb_debug_trigger_capture.sv ----
// Self-checking bench for the trigger and capture unit
`timescale 1ns/10ps
module tb_debug_trigger_capture import dtc_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite, background_opcode_cmd, e;
	logic        pready, pslverr, brk_tag, brk_force, cpu_wake, irq;
	logic [7:0]  paddr, db, d;
	logic [31:0] pwdata, prdata, seed, v;
	logic [15:0] ca, cb, x;
	logic [15:0] q [8]; // Expected capture contents
	dtc_bus_t    cpu_bus;
	dtc_core_t   core;
	int          n_errors, checks, nt, nf;
	localparam logic [11:0] f_tag = 12'h004;
	localparam logic [11:0] f_brk = 12'h008;
	localparam logic [11:0] f_beg = 12'h010;
	localparam logic [11:0] f_opq = 12'h020;
	localparam logic [11:0] f_rwa = 12'h040;
	dtc_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cpu_bus, .core, .background_opcode_cmd,
		.brk_tag, .brk_force, .cpu_wake, .irq);
	dtc_cpu_model cpu_u (.pclk, .presetn, .cpu_bus, .core, .brk_tag,
		.brk_force);
	task automatic end_of_test();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] ex);
		checks++;
		if (s !== ex) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, ex);
		end
	endtask
	// One APB transfer; bounded wait for ready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			end_of_test();
		end
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		chk(v & m, ex);
	endtask
	task automatic acc(input logic f, input logic rw, input logic [15:0] a,
		input logic [7:0] dd);
		cpu_u.step('{1'b1, f, rw, a, dd}, '0);
	endtask
	task automatic cor(input logic ev, input logic [15:0] a, input logic cv,
		input logic fl);
		cpu_u.step('0, '{ev, a, cv, a, fl});
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Control word: enable and arm set, mode and flags given
	function automatic logic [31:0] ctl(input logic [3:0] m,
		input logic [11:0] f);
		return {16'h0, m, f | 12'h003};
	endfunction
	// Expected trigger of one access in the single-step modes
	function automatic logic trig(input int m, input logic [15:0] a,
		input logic [7:0] dd);
		case (m)
			0: return a == ca;
			1: return a == ca || a == cb;
			5: return a == ca && dd == db;
			6: return a == ca && dd != db;
			7: return a >= ca && a <= cb;
			8: return a < ca || a > cb;
			default: return 1'b0;
		endcase
	endfunction
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, background_opcode_cmd} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		seed = 32'h0000e116;
		n_errors = 0;
		checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h00, 32'hffffffff, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, e}, 32'h1);
		v = rnd();
		ca = {1'b0, v[14:0]};
		cb = ca + 16'h40;
		db = v[23:16];
		wr(8'h04, {16'h0, ca});
		wr(8'h08, {8'h0, db, cb});
		// Single-access modes plus an unused code, as end-trace runs
		for (int i = 0; i < 10; i++) begin
			if (i > 1 && i < 5) continue;
			for (int k = 0; k < 7; k++) begin
				v = rnd();
				background_opcode_cmd <= v[31];
				x = k < 2 ? ca : k == 2 ? cb : k == 3 ? ca + 16'h20 :
					k == 4 ? ca - 16'h1 : k == 5 ? cb + 16'h1 : v[15:0];
				d = k[0] ? db : v[30:23];
				wr(8'h00, ctl(i[3:0], 12'h0));
				acc(1'b0, 1'b1, x, d);
				rchk(8'h0c, 32'h80,
					{24'h0, ~trig(i, x, d), 7'h0});
			end
		end
		// A then B with execution qualify; flushed opcode must not count
		wr(8'h00, ctl(4'h2, f_opq));
		acc(1'b1, 1'b1, ca, 8'h0);
		cor(1'b0, 16'h0, 1'b0, 1'b1);
		cor(1'b1, ca, 1'b0, 1'b0);
		acc(1'b1, 1'b1, cb, 8'h0);
		cor(1'b1, cb, 1'b0, 1'b0);
		rchk(8'h0c, 32'h80, 32'h80);
		acc(1'b1, 1'b1, ca, 8'h0);
		acc(1'b1, 1'b1, cb, 8'h0);
		cor(1'b1, ca, 1'b0, 1'b0);
		cor(1'b1, cb, 1'b0, 1'b0);
		rchk(8'h0c, 32'h80, 32'h0);
		// Direction qualify on A expecting a write
		wr(8'h00, ctl(4'h0, f_rwa));
		acc(1'b0, 1'b1, ca, 8'h0);
		rchk(8'h0c, 32'h80, 32'h80);
		acc(1'b0, 1'b0, ca, 8'h0);
		rchk(8'h0c, 32'h80, 32'h0);
		// Begin-trace run with force break, filled past full
		wr(8'h14, 32'h7);
		wr(8'h18, 32'h0);
		nf = cpu_u.n_force;
		wr(8'h00, ctl(4'h0, f_brk | f_beg));
		rchk(8'h0c, 32'hef, 32'h80);
		acc(1'b0, 1'b0, ca, 8'h0);
		repeat (3) @(posedge pclk);
		chk(cpu_u.n_force - nf, 32'h1);
		for (int i = 0; i < 9; i++) begin
			v = rnd();
			if (i < 8) q[i] = v[15:0];
			cor(1'b0, v[15:0], 1'b1, 1'b0);
			if (i == 2) rchk(8'h0c, 32'h8f, 32'h83);
		end
		rchk(8'h0c, 32'hef, 32'h48);
		for (int i = 0; i < 8; i++) begin
			rchk(8'h10, '1, {16'h0, q[i]});
		end
		rchk(8'h10, '1, 32'h0);
		// Sticky status, mask and write-one clear
		rchk(8'h14, 32'h7, 32'h5);
		chk({31'h0, irq}, 32'h0);
		wr(8'h18, 32'h4);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(8'h14, 32'h4);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		// Event-only modes: begin select left clear, data captured
		for (int m = 3; m < 5; m++) begin
			wr(8'h00, ctl(m[3:0], 12'h0));
			if (m == 4) acc(1'b0, 1'b1, ca, 8'h0);
			for (int i = 0; i < 9; i++) begin
				v = rnd();
				if (i < 8) q[i] = {8'h0, v[7:0]};
				acc(1'b0, 1'b1, cb, v[7:0]);
			end
			rchk(8'h0c, 32'h8f, 32'h08);
			for (int i = 0; i < 8; i++) begin
				rchk(8'h10, '1, {16'h0, q[i]});
			end
		end
		// End-trigger run: circular capture keeps the newest eight
		wr(8'h00, ctl(4'h0, 12'h0));
		for (int i = 0; i < 10; i++) begin
			v = rnd();
			if (i > 1) q[i-2] = v[15:0];
			cor(1'b0, v[15:0], 1'b1, 1'b0);
		end
		rchk(8'h0c, 32'h8f, 32'h88);
		acc(1'b0, 1'b1, ca, 8'h0);
		rchk(8'h0c, 32'h8f, 32'h08);
		for (int i = 0; i < 8; i++) begin
			rchk(8'h10, '1, {16'h0, q[i]});
		end
		// Tag break, then with break requests disabled
		nt = cpu_u.n_tag;
		nf = cpu_u.n_force;
		wr(8'h00, ctl(4'h0, f_tag | f_brk | f_beg));
		acc(1'b1, 1'b1, ca, 8'h0);
		wr(8'h00, ctl(4'h0, f_tag | f_beg));
		acc(1'b1, 1'b1, ca, 8'h0);
		repeat (3) @(posedge pclk);
		chk(cpu_u.n_tag - nt, 32'h1);
		chk(cpu_u.n_force - nf, 32'h0);
		// Manual stop by clearing arm, then by clearing enable
		for (int i = 1; i < 3; i++) begin
			wr(8'h00, ctl(4'h0, f_beg));
			wr(8'h00, i);
			rchk(8'h0c, 32'h80, 32'h0);
		end
		end_of_test();
	end
endmodule
